/* File: rtl/edge_detect_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "timer_edge_ff_map.vh"
module edge_detect_unit (
    input  wire       clock_i,   // Clock
    input  wire       nrst_i,    // Async reset, active low
    input  wire       pin_i,     // Raw timer input
    input  wire [1:0] sel_i,     // Edge select field
    output reg        event_o    // One-cycle edge pulse
);
    reg sync1_reg;
    reg sync2_reg;
    reg prev_reg;
    wire rise;
    wire fall;

    assign rise = sync2_reg & ~prev_reg;
    assign fall = ~sync2_reg & prev_reg;

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_reg <= 1'h0;
            sync2_reg <= 1'h0;
            prev_reg  <= 1'h0;
            event_o   <= 1'h0;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            case (sel_i)
                `EDGE_RISE: event_o <= rise;
                `EDGE_FALL: event_o <= fall;
                `EDGE_BOTH: event_o <= rise | fall;
                default:    event_o <= 1'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: rtl/timer_edge_ff_map.vh */
`ifndef TIMER_EDGE_FF_MAP_VH
`define TIMER_EDGE_FF_MAP_VH

`define EDGE_SEL_A_OFS     32'h00800218
`define EDGE_SEL_B_OFS     32'h0080021A
`define EDGE_SEL_RESET     16'h0000

`define EDGE_OFF           2'h0
`define EDGE_RISE          2'h1
`define EDGE_FALL          2'h2
`define EDGE_BOTH          2'h3

// Timer kinds
`define KIND_OUTPUT_P      3'h0
`define KIND_IO            3'h1
`define KIND_MEASURE_16    3'h2
`define KIND_MEASURE_32    3'h3
`define KIND_INPUT_COUNT   3'h4
`define KIND_OUTPUT_D      3'h5
`define KIND_OUTPUT_MULTI  3'h6

// Modes
`define MODE_PWM           3'h0
`define MODE_SINGLE        3'h1
`define MODE_DELAYED       3'h2
`define MODE_CONTINUOUS    3'h3
`define MODE_SINGLE_PWM    3'h4
`define MODE_MEAS_CLEAR    3'h5
`define MODE_MEAS_FREE     3'h6
`define MODE_NOISE         3'h7

`endif

/* File: rtl/timer_input_edge_and_output_ff_trigger.v */
`timescale 1ns/1ps
`default_nettype none
`include "timer_edge_ff_map.vh"
module timer_input_edge_and_output_ff_trigger #(
    parameter NUM_CH = 8                       // Timer channels served
) (
    input  wire                clock_i,        // Clock, 25 MHz
    input  wire                nrst_i,         // Async reset, active low
    input  wire [31:0]         addr_i,         // Register byte address
    input  wire [15:0]         wdata_i,        // Write data
    input  wire                wr_i,           // Write strobe
    input  wire                rd_i,           // Read strobe
    output reg  [15:0]         rdata_o,        // Read data, cycle after rd_i
    input  wire [15:0]         tin_i,          // Pins 12..23 (0..11), 30..33 (12..15)
    output reg  [15:0]         tin_event_o,    // Edge pulses, same order
    input  wire [3*NUM_CH-1:0] ch_kind_i,      // Per-channel timer kind
    input  wire [3*NUM_CH-1:0] ch_mode_i,      // Per-channel mode
    input  wire [NUM_CH-1:0]   ch_enable_i,    // Counter enable pulse
    input  wire [NUM_CH-1:0]   ch_underflow_i, // Counter underflow pulse
    output reg  [NUM_CH-1:0]   ff_trigger_o,   // Trigger pulse to output flip-flop
    output reg  [NUM_CH-1:0]   ff_out_o        // Timer output flip-flops
);
    ////////////////////////////////////////////////////////////////////////////
    reg  [15:0] edge_sel_a_reg;
    reg  [15:0] edge_sel_b_reg;
    wire [15:0] events;
    wire [31:0] sel_map;
    reg  [NUM_CH-1:0] trig_next;
    integer i;

    // Enable-trigger allowed for this kind and mode
    function on_enable;
        input [2:0] kind;
        input [2:0] mode;
        begin
            on_enable = 1'b0;
            case (kind)
                `KIND_OUTPUT_P, `KIND_IO, `KIND_OUTPUT_D, `KIND_OUTPUT_MULTI:
                    on_enable = (mode == `MODE_PWM) || (mode == `MODE_SINGLE) ||
                                (mode == `MODE_CONTINUOUS);
                default: on_enable = 1'b0;
            endcase
        end
    endfunction

    // Underflow-trigger allowed for this kind and mode
    function on_underflow;
        input [2:0] kind;
        input [2:0] mode;
        begin
            case (kind)
                `KIND_MEASURE_16, `KIND_MEASURE_32, `KIND_INPUT_COUNT:
                    on_underflow = 1'b0;
                `KIND_IO:
                    on_underflow = (mode != `MODE_SINGLE_PWM);
                `KIND_OUTPUT_MULTI:
                    on_underflow = (mode <= `MODE_SINGLE_PWM) &&
                                   (mode != `MODE_DELAYED);
                default:
                    on_underflow = (mode <= `MODE_CONTINUOUS);
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Field of input n is at bits 2k+1:2k, lowest bits holding the highest input
    assign sel_map = {edge_sel_b_reg[1:0], edge_sel_b_reg[3:2],
                      edge_sel_b_reg[5:4], edge_sel_b_reg[7:6],
                      edge_sel_b_reg[9:8], edge_sel_b_reg[11:10],
                      edge_sel_b_reg[13:12], edge_sel_b_reg[15:14],
                      edge_sel_a_reg[1:0], edge_sel_a_reg[3:2],
                      edge_sel_a_reg[5:4], edge_sel_a_reg[7:6],
                      edge_sel_a_reg[9:8], edge_sel_a_reg[11:10],
                      edge_sel_a_reg[13:12], edge_sel_a_reg[15:14]};

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : edge_gen
            edge_detect_unit u_edge (
                .clock_i (clock_i),
                .nrst_i  (nrst_i),
                .pin_i   (tin_i[g]),
                .sel_i   (sel_map[2*g+1:2*g]),
                .event_o (events[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Bus is halfword-only; software keeps to whole-halfword writes
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            edge_sel_a_reg <= `EDGE_SEL_RESET;
            edge_sel_b_reg <= `EDGE_SEL_RESET;
            rdata_o        <= 16'h0000;
        end else begin
            if (wr_i && addr_i == `EDGE_SEL_A_OFS)
                edge_sel_a_reg <= wdata_i;
            if (wr_i && addr_i == `EDGE_SEL_B_OFS)
                edge_sel_b_reg <= wdata_i;
            if (rd_i && addr_i == `EDGE_SEL_A_OFS)
                rdata_o <= edge_sel_a_reg;
            else if (rd_i && addr_i == `EDGE_SEL_B_OFS)
                rdata_o <= edge_sel_b_reg;
            else
                rdata_o <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Separate path from the event bus, so its timing is its own
    always @* begin
        trig_next = {NUM_CH{1'b0}};
        for (i = 0; i < NUM_CH; i = i + 1) begin
            trig_next[i] =
                (ch_enable_i[i] & on_enable(ch_kind_i[3*i+:3], ch_mode_i[3*i+:3])) |
                (ch_underflow_i[i] & on_underflow(ch_kind_i[3*i+:3], ch_mode_i[3*i+:3]));
        end
    end

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tin_event_o  <= 16'h0000;
            ff_trigger_o <= {NUM_CH{1'b0}};
            ff_out_o     <= {NUM_CH{1'b0}};
        end else begin
            tin_event_o  <= events;
            ff_trigger_o <= trig_next;
            ff_out_o     <= ff_out_o ^ trig_next;
        end
    end
endmodule
`default_nettype wire

/* File: tb/chan_model.sv */
`timescale 1ns/1ps
`default_nettype none
module chan_model #(
    parameter SPAN = 5
) (
    input  wire logic clock_i, // Clock
    input  wire logic go_i,    // Start count
    output var logic  en_o,    // Enable pulse
    output var logic  uf_o     // Underflow pulse
);
    int cnt = 0;
    initial {en_o, uf_o} = 2'b00;
    // Underflow comes SPAN cycles after enable, never in the same cycle
    always @(posedge clock_i) begin
        en_o <= go_i;
        uf_o <= (cnt == 1);
        cnt <= go_i ? SPAN : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule
`default_nettype wire

/* File: tb/test_timer_input_edge_and_output_ff_trigger.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_edge_ff_map.vh"
module test_timer_input_edge_and_output_ff_trigger;
    logic        clock_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, go = 0, en, uf, prev;
    logic [31:0] addr_i = 32'h0;
    logic [15:0] wdata_i = 16'h0, tin_i = 16'h0, rdata_o, tin_event_o;
    logic [23:0] ch_kind_i = 24'h0, ch_mode_i = 24'h0;
    logic [7:0]  ff_trigger_o, ff_out_o;
    int          num_errors = 0, cmp_count = 0, tc = 0, ev[16];
    // Kind, mode, expected trigger count
    localparam logic [7:0] TBL [13] = '{8'h06, 8'h09, 8'h0E, 8'h35, 8'h39, 8'h3D, 8'h22,
        8'h40, 8'h60, 8'h84, 8'hA2, 8'hD1, 8'hCE};
    chan_model #(.SPAN(5)) peer (.clock_i(clock_i), .go_i(go), .en_o(en), .uf_o(uf));
    timer_input_edge_and_output_ff_trigger #(.NUM_CH(8)) uut (
        .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tin_i(tin_i),
        .tin_event_o(tin_event_o), .ch_kind_i(ch_kind_i), .ch_mode_i(ch_mode_i),
        .ch_enable_i({8{en}}), .ch_underflow_i({8{uf}}),
        .ff_trigger_o(ff_trigger_o), .ff_out_o(ff_out_o));
    initial forever #20 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        tc += ff_trigger_o[0];
        foreach (ev[i]) ev[i] += tin_event_o[i];
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk("rdata", exp, rdata_o);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000 num_errors++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        wr(32'h0080021C, 16'hFFFF);
        rd(32'h0080021C, 16'h0000);
        rd(`EDGE_SEL_A_OFS, `EDGE_SEL_RESET);
        rd(`EDGE_SEL_B_OFS, `EDGE_SEL_RESET);
        for (int m = 0; m < 4; m++) begin
            wr(`EDGE_SEL_A_OFS, {m[1:0], 14'h0000});
            wr(`EDGE_SEL_B_OFS, {14'h0000, m[1:0]});
            rd(`EDGE_SEL_A_OFS, {m[1:0], 14'h0000});
            rd(`EDGE_SEL_B_OFS, {14'h0000, m[1:0]});
            ev = '{default: 0};
            @(posedge clock_i) tin_i <= 16'h8181;
            repeat (8) @(posedge clock_i);
            tin_i <= 16'h0000;
            repeat (8) @(posedge clock_i);
            #1 chk("ev12", 16'(m == 3 ? 2 : m != 0), 16'(ev[0]));
            chk("ev33", 16'(m == 3 ? 2 : m != 0), 16'(ev[15]));
            chk("ev19", 16'h0000, 16'(ev[7]));
            chk("ev20", 16'h0000, 16'(ev[8]));
        end
        foreach (TBL[i]) begin
            @(posedge clock_i);
            ch_kind_i <= {8{TBL[i][7:5]}};
            ch_mode_i <= {8{TBL[i][4:2]}};
            @(negedge clock_i) tc = 0;
            prev = ff_out_o[0];
            @(posedge clock_i) go <= 1'b1;
            @(posedge clock_i) go <= 1'b0;
            repeat (10) @(posedge clock_i);
            #1 chk("trig", {14'h0000, TBL[i][1:0]}, 16'(tc));
            chk("ffout", {15'h0000, prev ^ TBL[i][0]}, {15'h0000, ff_out_o[0]});
        end
        conclude();
    end
endmodule
`default_nettype wire

/* File: tb/trig_edge_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_edge_ff_map.vh"
module trig_edge_checker #(
    parameter NUM_CH = 8
) (
    input wire logic                clock_i,
    input wire logic                nrst_i,
    input wire logic [31:0]         addr_i,
    input wire logic [15:0]         wdata_i,
    input wire logic                wr_i,
    input wire logic [15:0]         tin_event_o,
    input wire logic [3*NUM_CH-1:0] ch_kind_i,
    input wire logic [3*NUM_CH-1:0] ch_mode_i,
    input wire logic [NUM_CH-1:0]   ch_enable_i,
    input wire logic [NUM_CH-1:0]   ch_underflow_i,
    input wire logic [NUM_CH-1:0]   ff_trigger_o,
    input wire logic [NUM_CH-1:0]   ff_out_o
);
    logic [1:0] f12_reg;
    wire  [2:0] k0 = ch_kind_i[2:0];
    wire  [2:0] m0 = ch_mode_i[2:0];
    wire        en0 = ch_enable_i[0] && !ch_underflow_i[0];
    // Shadow of the input 12 field, so edge checks need no internal probe
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            f12_reg <= 2'h0;
        else if (wr_i && addr_i == `EDGE_SEL_A_OFS)
            f12_reg <= wdata_i[15:14];
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence field_off; (f12_reg == 2'h0)[*6]; endsequence
    a_ff_toggle: assert property (
        ff_trigger_o[0] |-> ff_out_o[0] != $past(ff_out_o[0])) else $error("no toggle");
    a_ff_hold: assert property (
        !ff_trigger_o[0] |-> $stable(ff_out_o[0])) else $error("stray toggle");
    a_trig_cause: assert property (
        ff_trigger_o[0] |-> $past(ch_enable_i[0] || ch_underflow_i[0])) else $error("no cause");
    a_meas_silent: assert property (
        $past(k0 == `KIND_MEASURE_16 || k0 == `KIND_MEASURE_32) |-> !ff_trigger_o[0])
        else $error("measure trigger");
    a_uf_trig: assert property (
        $past(ch_underflow_i[0] && k0 == `KIND_OUTPUT_P && m0 == `MODE_SINGLE)
        |-> ff_trigger_o[0]) else $error("underflow missed");
    a_en_trig: assert property (
        $past(en0 && k0 == `KIND_OUTPUT_P && m0 == `MODE_CONTINUOUS)
        |-> ff_trigger_o[0]) else $error("enable missed");
    a_only_uf: assert property (
        $past(en0 && (m0 == `MODE_DELAYED || m0 == `MODE_SINGLE_PWM
        || m0 >= `MODE_MEAS_CLEAR)) |-> !ff_trigger_o[0]) else $error("enable trigger");
    a_edge_off: assert property (
        field_off |=> !tin_event_o[0]) else $error("ignored input fired");
endmodule
bind timer_input_edge_and_output_ff_trigger trig_edge_checker #(.NUM_CH(NUM_CH)) chk (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .tin_event_o(tin_event_o), .ch_kind_i(ch_kind_i), .ch_mode_i(ch_mode_i),
    .ch_enable_i(ch_enable_i), .ch_underflow_i(ch_underflow_i),
    .ff_trigger_o(ff_trigger_o), .ff_out_o(ff_out_o));
`default_nettype wire
